/* verilog/bdc_pkg.sv */
// Purpose: Constants and types for the two-bridge constant off-time chopper.
// Assumes: 125 MHz system clock; register bus is Avalon-MM with waitrequest.
// Notes: Times are kept in ns and turned into cycle counts here.
// Contract
// - Insert a dead interval between one leg transistor off and the other on.
// - Two independent chopper controllers, each with own sense, reference and off timer.
// - Sense above reference triggers off-time timer and ends on state.
// - Stay off for the whole timer, then return to on.
// - Effective off interval is timer duration plus one dead interval.
// - Mask comparator for 1 us after a transistor turns on.
// - Enforce a minimum on interval of 1.5 us before a trip ends it.
// - Short on intervals still work; off interval may then vary.
// - Off timer duration is programmable, range about 6.6 us to 6 ms; the code clamps to 5.6 us to 5.999 ms.
// - Decay select low gives fast decay: both conducting transistors off.
// - Decay select high gives slow decay: only the low-side switched off.
// - Fast decay rectifies with the low-side beside the diode only.
// - Fast decay restores on-state transistors only after a dead interval.
// - Slow decay drives opposite high-side in synchronous rectification after dead interval.
// - Slow decay turns low-side back on only after a dead interval.
// - Enable line is shared with the internal fault open-drain pull-down.
// - Sequencer phase and enable controls set each bridge's polarity and activation.
// - On overcurrent fault the device pulls the enable line low.
package bdc_pkg;
  localparam int CLK_NS = 8;
  localparam int DEAD_NS = 1000;
  localparam int BLANK_NS = 1000;
  localparam int MIN_ON_NS = 1500;
  localparam int OFF_MIN_NS = 5600;
  localparam int OFF_MAX_NS = 5999000;
  localparam logic [9:0] DEAD_CYC = 10'((DEAD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [9:0] BLANK_CYC = 10'((BLANK_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [9:0] MIN_ON_CYC = 10'((MIN_ON_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [19:0] OFF_MIN_CYC = 20'((OFF_MIN_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [19:0] OFF_MAX_CYC = 20'(OFF_MAX_NS / CLK_NS);
  localparam logic [19:0] OFF_RST = 20'h02710;
  // Register word offsets (byte addresses).
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_OFFA = 4'h4;
  localparam logic [3:0] ADDR_OFFB = 4'h8;
  localparam logic [3:0] ADDR_STAT = 4'hC;
  // Control register bit positions and reset value.
  localparam int CTRL_DECAY = 0;
  localparam int CTRL_FAULT = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  typedef enum logic [2:0] {BDC_IDLE, BDC_DEAD_ON, BDC_ON, BDC_DEAD_OFF, BDC_OFF, BDC_DEAD_RET} bdc_st_t;
endpackage : bdc_pkg

/* verilog/bdc_top.sv */
// Purpose: Two constant off-time choppers with decay patterns and dead intervals.
// Assumes: All inputs except arst_n synchronous to sys_clk; comparators are digital inputs.
// Notes: Gate outputs per bridge: [0] high-side A leg, [1] low-side A,
//   [2] high-side B leg, [3] low-side B. Phase high makes HA and LB the pair.
`timescale 1ns/100ps
module bdc_top
  import bdc_pkg::*;
(
  input wire logic sys_clk, // System clock, 125 MHz.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic [1:0] trip, // Sense above reference, per bridge.
  input wire logic [1:0] phase, // Drive polarity per bridge.
  input wire logic [1:0] bridge_en, // Sequencer enable per bridge.
  input wire logic decay_sel, // Decay select pin, high is slow decay.
  input wire logic enable_in, // Level seen on the shared enable line.
  input wire logic fault_det, // Overcurrent or thermal fault level.
  output logic enable_o, // Enable line driven low by the pull-down.
  output logic enable_oe, // Pull-down active.
  output logic [3:0] gate_a, // Gates of bridge A.
  output logic [3:0] gate_b, // Gates of bridge B.
  input wire logic [3:0] avs_address, // Byte address.
  input wire logic avs_read, // Read request.
  input wire logic avs_write, // Write request.
  input wire logic [31:0] avs_writedata, // Write data.
  output logic [31:0] avs_readdata, // Read data.
  output logic avs_waitrequest // Wait request.
);
  typedef struct packed {
    bdc_st_t [1:0] st;
    logic [1:0][19:0] cnt;
    logic [1:0][9:0] ton;
    logic [1:0] slow;
    logic [1:0] ph;
    logic [1:0][19:0] offc;
    logic [1:0] ctrl;
    logic acked;
    logic [31:0] rdata;
    logic [1:0][3:0] gate;
  } bdc_state_t;

  bdc_state_t s;
  bdc_state_t next_s;
  logic en_ok;
  logic [1:0] gated_trip;

  // Clamp an off-time value into the supported range.
  function automatic logic [19:0] clamp_off(input logic [31:0] v);
    logic [19:0] r;
    r = v[19:0];
    if (v > {12'h000, OFF_MAX_CYC}) begin
      r = OFF_MAX_CYC;
    end else if (v[19:0] < OFF_MIN_CYC) begin
      r = OFF_MIN_CYC;
    end
    return r;
  endfunction : clamp_off

  // Gate pattern from state, phase and decay choice.
  function automatic logic [3:0] pattern(input bdc_st_t st, input logic ph, input logic slow);
    logic [3:0] g;
    g = 4'h0;
    case (st)
      BDC_ON: g = ph ? 4'h9 : 4'h6;
      BDC_DEAD_OFF, BDC_DEAD_RET: g = slow ? (ph ? 4'h1 : 4'h4) : 4'h0;
      BDC_OFF: g = slow ? 4'h5 : (ph ? 4'h2 : 4'h8);
      default: g = 4'h0;
    endcase
    return g;
  endfunction : pattern

  // Fault pull-down shares the enable line; device only sinks, never sources.
  assign enable_o = 1'b0;
  assign enable_oe = fault_det | s.ctrl[CTRL_FAULT];
  assign en_ok = enable_in & ~enable_oe;
  assign gate_a = s.gate[0];
  assign gate_b = s.gate[1];
  assign avs_readdata = s.rdata;
  assign avs_waitrequest = (avs_read | avs_write) & ~s.acked;

  // Per-bridge sequencing, then bus access.
  always_comb begin
    next_s = s;
    gated_trip = 2'h0;
    for (int i = 0; i < 2; i++) begin
      if (next_s.ton[i] != 10'h3FF) begin
        next_s.ton[i] = s.ton[i] + 10'h001;
      end
      next_s.cnt[i] = s.cnt[i] + 20'h00001;
      // Blanking and minimum on time both hold the trip off; min-on covers blanking.
      gated_trip[i] = trip[i] && s.ton[i] >= BLANK_CYC && s.ton[i] >= MIN_ON_CYC;
      if (!en_ok || !bridge_en[i]) begin
        next_s.st[i] = BDC_IDLE;
      end else begin
        case (s.st[i])
          BDC_IDLE: begin
            next_s.st[i] = BDC_DEAD_ON;
            next_s.cnt[i] = 20'h00000;
            next_s.ph[i] = phase[i];
          end
          BDC_DEAD_ON, BDC_DEAD_RET: begin
            if (s.cnt[i] >= {10'h000, DEAD_CYC} - 20'h00001) begin
              next_s.st[i] = BDC_ON;
              next_s.ton[i] = 10'h000;
            end
          end
          BDC_ON: begin
            if (gated_trip[i]) begin
              next_s.st[i] = BDC_DEAD_OFF;
              next_s.cnt[i] = 20'h00000;
              next_s.slow[i] = decay_sel;
            end else if (phase[i] != s.ph[i]) begin
              // A polarity flip would swap both legs at once, so it passes through a dead interval.
              next_s.st[i] = BDC_DEAD_ON;
              next_s.cnt[i] = 20'h00000;
              next_s.ph[i] = phase[i];
            end
          end
          BDC_DEAD_OFF: begin
            // Timer runs from the trip; dead interval is part of it.
            if (s.cnt[i] >= {10'h000, DEAD_CYC} - 20'h00001) begin
              next_s.st[i] = BDC_OFF;
            end
          end
          BDC_OFF: begin
            // Short on intervals need no recharge wait; holds trivially.
            if (s.cnt[i] >= s.offc[i] - 20'h00001) begin
              next_s.st[i] = BDC_DEAD_RET;
              next_s.cnt[i] = 20'h00000;
            end
          end
          default: next_s.st[i] = BDC_IDLE;
        endcase
      end
      next_s.gate[i] = pattern(next_s.st[i], next_s.ph[i], next_s.slow[i]);
    end
    // Avalon slave: one wait cycle, then answer.
    next_s.acked = 1'b0;
    if ((avs_read | avs_write) && !s.acked) begin
      next_s.acked = 1'b1;
      next_s.rdata = 32'h00000000;
      if (avs_write) begin
        case (avs_address)
          ADDR_CTRL: next_s.ctrl = avs_writedata[1:0];
          ADDR_OFFA: next_s.offc[0] = clamp_off(avs_writedata);
          ADDR_OFFB: next_s.offc[1] = clamp_off(avs_writedata);
          default: next_s.acked = 1'b1;
        endcase
      end else begin
        case (avs_address)
          ADDR_CTRL: next_s.rdata = {30'h0, s.ctrl};
          ADDR_OFFA: next_s.rdata = {12'h000, s.offc[0]};
          ADDR_OFFB: next_s.rdata = {12'h000, s.offc[1]};
          ADDR_STAT: next_s.rdata = {23'h0, enable_oe, en_ok, 1'b0, s.st[1], s.st[0]};
          default: next_s.rdata = 32'h00000000;
        endcase
      end
    end
  end

  // Register the whole state.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
      s.offc <= {OFF_RST, OFF_RST};
      s.ctrl <= CTRL_RST;
    end else begin
      s <= next_s;
    end
  end

  // Decay select in the control register is unused; the pin governs decay.
  property p_dead_before_on;
    @(posedge sys_clk) disable iff (!arst_n)
      $rose(s.st[0] == BDC_ON) |-> $past(s.st[0] == BDC_DEAD_ON || s.st[0] == BDC_DEAD_RET);
  endproperty
  a_dead_before_on: assert property (p_dead_before_on) else $error("On without dead interval.");
  property p_no_shoot;
    @(posedge sys_clk) disable iff (!arst_n)
      !(gate_a[0] && gate_a[1]) && !(gate_a[2] && gate_a[3]);
  endproperty
  a_no_shoot: assert property (p_no_shoot) else $error("Leg cross conduction.");
  property p_trip;
    @(posedge sys_clk) disable iff (!arst_n)
      s.st[0] == BDC_ON && gated_trip[0] && en_ok && bridge_en[0] |=> s.st[0] == BDC_DEAD_OFF;
  endproperty
  a_trip: assert property (p_trip) else $error("Trip did not end on state.");
  property p_min_on;
    @(posedge sys_clk) disable iff (!arst_n)
      s.st[0] == BDC_ON && s.ton[0] < MIN_ON_CYC && en_ok && bridge_en[0] |=> s.st[0] != BDC_DEAD_OFF;
  endproperty
  a_min_on: assert property (p_min_on) else $error("On interval ended early.");
  property p_disable;
    @(posedge sys_clk) disable iff (!arst_n)
      !en_ok |=> gate_a == 4'h0 && gate_b == 4'h0;
  endproperty
  a_disable: assert property (p_disable) else $error("Gates on while disabled.");
  property p_fast;
    @(posedge sys_clk) disable iff (!arst_n)
      s.st[0] == BDC_OFF && !s.slow[0] |-> gate_a[0] == 1'b0 && gate_a[2] == 1'b0;
  endproperty
  a_fast: assert property (p_fast) else $error("High-side used in fast decay.");
  property p_slow;
    @(posedge sys_clk) disable iff (!arst_n)
      s.st[0] == BDC_OFF && s.slow[0] |-> gate_a == 4'h5;
  endproperty
  a_slow: assert property (p_slow) else $error("Slow decay pattern wrong.");
  property p_diag;
    @(posedge sys_clk) disable iff (!arst_n)
      s.st[0] == BDC_ON && $past(s.st[0] == BDC_ON) |-> gate_a == ($past(phase[0]) ? 4'h9 : 4'h6);
  endproperty
  a_diag: assert property (p_diag) else $error("Wrong diagonal.");
  property p_fault;
    @(posedge sys_clk) disable iff (!arst_n)
      fault_det |-> enable_oe && !enable_o;
  endproperty
  a_fault: assert property (p_fault) else $error("Fault did not pull enable.");
  // Bridge B runs the same sequencer; these checks mirror the bridge A ones.
  property p_dead_before_on_b;
    @(posedge sys_clk) disable iff (!arst_n)
      $rose(s.st[1] == BDC_ON) |-> $past(s.st[1] == BDC_DEAD_ON || s.st[1] == BDC_DEAD_RET);
  endproperty
  a_dead_before_on_b: assert property (p_dead_before_on_b) else $error("Bridge B on without dead interval.");
  property p_no_shoot_b;
    @(posedge sys_clk) disable iff (!arst_n)
      !(gate_b[0] && gate_b[1]) && !(gate_b[2] && gate_b[3]);
  endproperty
  a_no_shoot_b: assert property (p_no_shoot_b) else $error("Bridge B leg cross conduction.");
  property p_trip_b;
    @(posedge sys_clk) disable iff (!arst_n)
      s.st[1] == BDC_ON && gated_trip[1] && en_ok && bridge_en[1] |=> s.st[1] == BDC_DEAD_OFF;
  endproperty
  a_trip_b: assert property (p_trip_b) else $error("Bridge B trip did not end on state.");
  property p_min_on_b;
    @(posedge sys_clk) disable iff (!arst_n)
      s.st[1] == BDC_ON && s.ton[1] < MIN_ON_CYC && en_ok && bridge_en[1] |=> s.st[1] != BDC_DEAD_OFF;
  endproperty
  a_min_on_b: assert property (p_min_on_b) else $error("Bridge B on interval ended early.");
  property p_fast_b;
    @(posedge sys_clk) disable iff (!arst_n)
      s.st[1] == BDC_OFF && !s.slow[1] |-> gate_b[0] == 1'b0 && gate_b[2] == 1'b0;
  endproperty
  a_fast_b: assert property (p_fast_b) else $error("Bridge B high-side used in fast decay.");
  property p_slow_b;
    @(posedge sys_clk) disable iff (!arst_n)
      s.st[1] == BDC_OFF && s.slow[1] |-> gate_b == 4'h5;
  endproperty
  a_slow_b: assert property (p_slow_b) else $error("Bridge B slow decay pattern wrong.");
  property p_diag_b;
    @(posedge sys_clk) disable iff (!arst_n)
      s.st[1] == BDC_ON && $past(s.st[1] == BDC_ON) |-> gate_b == ($past(phase[1]) ? 4'h9 : 4'h6);
  endproperty
  a_diag_b: assert property (p_diag_b) else $error("Bridge B wrong diagonal.");
  // Dead intervals last exactly DEAD_CYC cycles; an early exit would risk shoot-through.
  property p_dead_len;
    @(posedge sys_clk) disable iff (!arst_n)
      $rose(s.st[0] == BDC_DEAD_OFF) |-> ##124 s.st[0] != BDC_OFF ##1 s.st[0] != BDC_DEAD_OFF;
  endproperty
  a_dead_len: assert property (p_dead_len) else $error("Off dead interval wrong length.");
  property p_ret_len;
    @(posedge sys_clk) disable iff (!arst_n)
      $rose(s.st[0] == BDC_DEAD_RET) |-> ##124 s.st[0] != BDC_ON ##1 s.st[0] != BDC_DEAD_RET;
  endproperty
  a_ret_len: assert property (p_ret_len) else $error("Return dead interval wrong length.");
  property p_dead_len_b;
    @(posedge sys_clk) disable iff (!arst_n)
      $rose(s.st[1] == BDC_DEAD_OFF) |-> ##124 s.st[1] != BDC_OFF ##1 s.st[1] != BDC_DEAD_OFF;
  endproperty
  a_dead_len_b: assert property (p_dead_len_b) else $error("Bridge B off dead interval wrong length.");
  property p_ret_len_b;
    @(posedge sys_clk) disable iff (!arst_n)
      $rose(s.st[1] == BDC_DEAD_RET) |-> ##124 s.st[1] != BDC_ON ##1 s.st[1] != BDC_DEAD_RET;
  endproperty
  a_ret_len_b: assert property (p_ret_len_b) else $error("Bridge B return dead interval wrong length.");
  // Per leg, the partner gate stays off for a while after one gate falls.
  property p_leg_a_hi;
    @(posedge sys_clk) disable iff (!arst_n)
      $fell(gate_a[1]) |-> (!gate_a[0]) [*8];
  endproperty
  a_leg_a_hi: assert property (p_leg_a_hi) else $error("Leg A high-side on too soon.");
  property p_leg_a_lo;
    @(posedge sys_clk) disable iff (!arst_n)
      $fell(gate_a[0]) |-> (!gate_a[1]) [*8];
  endproperty
  a_leg_a_lo: assert property (p_leg_a_lo) else $error("Leg A low-side on too soon.");
  property p_leg_b_hi;
    @(posedge sys_clk) disable iff (!arst_n)
      $fell(gate_a[3]) |-> (!gate_a[2]) [*8];
  endproperty
  a_leg_b_hi: assert property (p_leg_b_hi) else $error("Leg B high-side on too soon.");
  property p_leg_b_lo;
    @(posedge sys_clk) disable iff (!arst_n)
      $fell(gate_a[2]) |-> (!gate_a[3]) [*8];
  endproperty
  a_leg_b_lo: assert property (p_leg_b_lo) else $error("Leg B low-side on too soon.");
  // The same leg checks on bridge B.
  property p_bleg_a_hi;
    @(posedge sys_clk) disable iff (!arst_n)
      $fell(gate_b[1]) |-> (!gate_b[0]) [*8];
  endproperty
  a_bleg_a_hi: assert property (p_bleg_a_hi) else $error("Bridge B leg A high-side on too soon.");
  property p_bleg_a_lo;
    @(posedge sys_clk) disable iff (!arst_n)
      $fell(gate_b[0]) |-> (!gate_b[1]) [*8];
  endproperty
  a_bleg_a_lo: assert property (p_bleg_a_lo) else $error("Bridge B leg A low-side on too soon.");
  property p_bleg_b_hi;
    @(posedge sys_clk) disable iff (!arst_n)
      $fell(gate_b[3]) |-> (!gate_b[2]) [*8];
  endproperty
  a_bleg_b_hi: assert property (p_bleg_b_hi) else $error("Bridge B leg B high-side on too soon.");
  property p_bleg_b_lo;
    @(posedge sys_clk) disable iff (!arst_n)
      $fell(gate_b[2]) |-> (!gate_b[3]) [*8];
  endproperty
  a_bleg_b_lo: assert property (p_bleg_b_lo) else $error("Bridge B leg B low-side on too soon.");
  // Off timer holds and releases on its count, and the bus answers after one wait cycle.
  property p_off_hold;
    @(posedge sys_clk) disable iff (!arst_n)
      s.st[0] == BDC_OFF && s.cnt[0] < s.offc[0] - 20'h00001 && en_ok && bridge_en[0] |=> s.st[0] == BDC_OFF;
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("Off interval cut short.");
  property p_off_hold_b;
    @(posedge sys_clk) disable iff (!arst_n)
      s.st[1] == BDC_OFF && s.cnt[1] < s.offc[1] - 20'h00001 && en_ok && bridge_en[1] |=> s.st[1] == BDC_OFF;
  endproperty
  a_off_hold_b: assert property (p_off_hold_b) else $error("Bridge B off interval cut short.");
  property p_off_end;
    @(posedge sys_clk) disable iff (!arst_n)
      s.st[0] == BDC_OFF && s.cnt[0] >= s.offc[0] - 20'h00001 && en_ok && bridge_en[0] |=> s.st[0] == BDC_DEAD_RET;
  endproperty
  a_off_end: assert property (p_off_end) else $error("Off interval did not end.");
  property p_offc_range;
    @(posedge sys_clk) disable iff (!arst_n)
      s.offc[0] >= OFF_MIN_CYC && s.offc[0] <= OFF_MAX_CYC &&
      s.offc[1] >= OFF_MIN_CYC && s.offc[1] <= OFF_MAX_CYC;
  endproperty
  a_offc_range: assert property (p_offc_range) else $error("Off count out of range.");
  property p_bus_wait;
    @(posedge sys_clk) disable iff (!arst_n)
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_bus_wait: assert property (p_bus_wait) else $error("Bus answer late.");
  c_trip: cover property (@(posedge sys_clk) disable iff (!arst_n) s.st[0] == BDC_DEAD_OFF);
  c_ret: cover property (@(posedge sys_clk) disable iff (!arst_n) s.st[1] == BDC_DEAD_RET);
  c_slow: cover property (@(posedge sys_clk) disable iff (!arst_n) s.st[0] == BDC_OFF && s.slow[0]);
  // Fast decay and a polarity flip are the remaining paths worth seeing.
  c_fast: cover property (@(posedge sys_clk) disable iff (!arst_n) s.st[1] == BDC_OFF && !s.slow[1]);
  c_flip: cover property (@(posedge sys_clk) disable iff (!arst_n) s.st[1] == BDC_DEAD_ON && $past(s.st[1] == BDC_ON));
endmodule : bdc_top

/* testbench/bdc_line_model.sv */
// Purpose: Shared enable line: controller open-drain pull-up with R-C, device pull-down.
// Assumes: The line reads low while any party sinks it.
// Notes: The rise is delayed by RISE_CYC cycles to mimic the R-C charge.
`timescale 1ns/100ps
module bdc_line_model #(
  parameter int RISE_CYC = 6
) (
  input wire logic sys_clk, // System clock.
  input wire logic ctl_low, // Controller sinks the line.
  input wire logic enable_o, // Device drive level.
  input wire logic enable_oe, // Device pull-down on.
  output logic enable_in // Resolved line level.
);
  int cnt = 0;
  // The controller only sinks, so it can never override the device pull-down.
  always @(posedge sys_clk) begin
    if (ctl_low || (enable_oe && !enable_o)) cnt <= 0;
    else if (cnt < RISE_CYC) cnt <= cnt + 1;
  end
  // A falling line follows at once; a rising one waits for the capacitor.
  assign enable_in = (cnt == RISE_CYC) && !ctl_low && !(enable_oe && !enable_o);
endmodule : bdc_line_model

/* testbench/bridge_chopper_decay_control_test.sv */
// Purpose: Self-checking bench for the two-bridge off-time chopper.
// Assumes: Trips are driven directly; the line model resolves the enable line.
// Notes: Off counts are shortened through the bus so the run stays short.
`timescale 1ns/100ps
module bridge_chopper_decay_control_test;
  import bdc_pkg::*;
  typedef struct {string n; logic [31:0] v;} bdc_exp_t;
  bdc_exp_t exp_q[$];
  bdc_exp_t e;
  logic sys_clk = 1'h0, arst_n = 1'h0, decay_sel = 1'h0, fault_det = 1'h0, ctl_low = 1'h1;
  logic [1:0] trip = 2'h0, phase = 2'h1, bridge_en = 2'h0;
  logic avs_read = 1'h0, avs_write = 1'h0, gchk = 1'h0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [3:0] gate_a, gate_b;
  logic enable_in, enable_o, enable_oe, avs_waitrequest;
  int miscompares = 0, checks_done = 0;
  logic [19:0] off [2];
  bdc_top uut (.sys_clk, .arst_n, .trip, .phase, .bridge_en, .decay_sel, .enable_in, .fault_det, .enable_o,
    .enable_oe, .gate_a, .gate_b, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest);
  bdc_line_model lm (.sys_clk, .ctl_low, .enable_o, .enable_oe, .enable_in);
  // Free-running system clock, 8 ns period.
  always #4 sys_clk = ~sys_clk;
  task automatic check(string n, logic [31:0] s, logic [31:0] x);
    checks_done++;
    if (s !== x) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, x, s);
    end
  endtask : check
  // Results are matched in order, so a missing answer shifts every later compare.
  always @(posedge sys_clk) begin
    if (exp_q.size() > 0 && ((avs_read && !avs_waitrequest) || gchk)) begin
      e = exp_q.pop_front();
      check(e.n, gchk ? {23'h0, gate_b, gate_a, enable_oe} : avs_readdata, e.v);
    end
  end
  task automatic bus(logic w, logic [3:0] a, logic [31:0] d, string n = "", logic [31:0] x = 32'h0);
    if (!w) exp_q.push_back('{n, x});
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    @(posedge sys_clk);
  endtask : bus
  // The gate sample seen is the state launched at the edge where this is entered.
  task automatic chk(string n, logic [8:0] x);
    exp_q.push_back('{n, {23'h0, x}});
    gchk <= 1'h1;
    @(posedge sys_clk);
    gchk <= 1'h0;
    @(posedge sys_clk);
  endtask : chk
  function automatic logic [8:0] gv(bit b, logic [3:0] x, logic [3:0] o);
    return b ? {x, o, 1'h0} : {o, x, 1'h0};
  endfunction : gv
  // One chopping cycle on bridge b; the other bridge must stay in its on pattern.
  task automatic decay(bit b, logic slow);
    logic [3:0] on, o, dd, of;
    on = b ? 4'h6 : 4'h9;
    o = b ? 4'h9 : 4'h6;
    dd = !slow ? 4'h0 : (b ? 4'h4 : 4'h1);
    of = !slow ? (b ? 4'h8 : 4'h2) : 4'h5;
    repeat (200) @(posedge sys_clk);
    decay_sel <= slow;
    trip[b] <= 1'h1;
    repeat (4) @(posedge sys_clk);
    chk("dead_off", gv(b, dd, o));
    trip[b] <= 1'h0;
    repeat (134) @(posedge sys_clk);
    chk("off", gv(b, of, o));
    repeat (off[b] - 21) @(posedge sys_clk);
    chk("dead_ret", gv(b, dd, o));
    repeat (8) @(posedge sys_clk);
    chk("on", gv(b, on, o));
    trip[b] <= 1'h1;
    repeat (170) @(posedge sys_clk);
    chk("blank", gv(b, on, o));
    trip[b] <= 1'h0;
  endtask : decay
  task automatic end_sim;
    $display("checks_done %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  // Main sequence: registers, chopping in both modes on both bridges, then enable line.
  initial begin
    void'($urandom(32'hB378));
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'h1;
    @(posedge sys_clk);
    bus(1'h0, ADDR_CTRL, 32'h0, "ctrl", 32'(CTRL_RST));
    bus(1'h0, ADDR_OFFA, 32'h0, "offa", 32'(OFF_RST));
    bus(1'h0, 4'h2, 32'h0, "unmapped", 32'h0);
    bus(1'h1, ADDR_OFFA, 32'h5);
    bus(1'h0, ADDR_OFFA, 32'h0, "clamp_lo", 32'(OFF_MIN_CYC));
    bus(1'h1, ADDR_OFFB, 32'hFFFFF);
    bus(1'h0, ADDR_OFFB, 32'h0, "clamp_hi", 32'(OFF_MAX_CYC));
    for (int i = 0; i < 2; i++) begin
      off[i] = 20'(700 + $urandom_range(500));
      bus(1'h1, i ? ADDR_OFFB : ADDR_OFFA, 32'(off[i]));
    end
    $display("test registers done");
    ctl_low <= 1'h0;
    bridge_en <= 2'h3;
    repeat (150) @(posedge sys_clk);
    chk("on_both", 9'h0D2);
    for (int i = 0; i < 4; i++) decay(i[1], i[0]);
    $display("test decay done");
    ctl_low <= 1'h1;
    repeat (4) @(posedge sys_clk);
    chk("disabled", 9'h000);
    ctl_low <= 1'h0;
    fault_det <= 1'h1;
    repeat (10) @(posedge sys_clk);
    chk("fault", 9'h001);
    fault_det <= 1'h0;
    bus(1'h1, ADDR_CTRL, 32'h2);
    bus(1'h0, ADDR_CTRL, 32'h0, "force", 32'h2);
    chk("force_pd", 9'h001);
    bus(1'h1, ADDR_CTRL, 32'h0);
    repeat (150) @(posedge sys_clk);
    chk("resume", 9'h0D2);
    phase <= 2'h3;
    repeat (4) @(posedge sys_clk);
    chk("flip_dead", 9'h012);
    repeat (150) @(posedge sys_clk);
    chk("flip_on", 9'h132);
    bus(1'h0, ADDR_STAT, 32'h0, "stat", 32'h00000092);
    $display("test enable done");
    end_sim();
  end
  // Watchdog: the whole sequence needs well under 20000 cycles.
  initial begin
    #(8 * 20000);
    miscompares++;
    end_sim();
  end
endmodule : bridge_chopper_decay_control_test
